// *** design/i2c_evt_pkg.sv ***
// Constants, register map and field layout of the bus event status block
// Summary of operation
// - Wait-release in transmit state cancels the wait
// - That release clears transmit state, floats data
// - Ack flag set: data low, ninth rise
// - Ack cleared: stop, next first clock, exit, disable
// - Start flag set on start condition
// - Start cleared: stop, post-address clock, exit, disable
// - Stop flag set on stop condition
// - Stop held until next address first clock
package i2c_evt_pkg;
   // ************************************************************
   // Register bus
   // ************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h3;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_STOP = 0;
   localparam int BIT_START = 1;
   localparam int BIT_ACK = 2;
   localparam int BIT_TX_STATE = 3;
   localparam int BIT_WAIT_REL = 5;
   localparam int BIT_COMM_EXIT = 6;
   localparam int BIT_ENABLE = 7;
   // ************************************************************
   // Reset values and counts
   // ************************************************************
   localparam logic [2:0] EVT_RESET = 3'h0;
   localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
   localparam logic [3:0] CNT_IDLE = 4'h0;
   localparam logic [3:0] CNT_FIRST = 4'h1;
   localparam logic [3:0] CNT_EIGHTH = 4'h8;
   localparam logic [3:0] CNT_NINTH = 4'h9;
endpackage : i2c_evt_pkg

// *** design/pin_sync.sv ***
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Asynchronous and synchronised levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         meta <= '1;
         o_sync <= '1;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule : pin_sync

// *** design/i2c_bus_event_status_flags.sv ***
// Acknowledge, start and stop event flags with wait and register port
`timescale 1ns/1ps
module i2c_bus_event_status_flags (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Register port
   input wire logic [i2c_evt_pkg::ADDR_W-1:0] i_addr,
   input wire logic [i2c_evt_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [i2c_evt_pkg::DATA_W-1:0] o_rdata,
   // Shift and address logic on the same clock
   input wire logic i_tx_state_set,
   input wire logic i_tx_bit,
   input wire logic i_shift_write,
   // Bus pins
   input wire logic i_clock_line_pin,
   output logic o_clock_line_pin,
   output logic o_clock_line_pin_oe_n,
   input wire logic i_data_line_pin,
   output logic o_data_line_pin,
   output logic o_data_line_pin_oe_n,
   // Status and interrupt
   output logic o_transmit_state_flag,
   output logic o_irq
);
   import i2c_evt_pkg::*;

   // ************************************************************
   // Pin sampling and bus conditions
   // ************************************************************
   logic [1:0] pins_sync;
   logic scl_s;
   logic sda_s;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   pin_sync #(.WIDTH(2)) u_pin_sync (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_async({i_clock_line_pin, i_data_line_pin}),
      .o_sync(pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   // Previous synchronised levels for edge finding
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // Data edges while clock stays high are bus conditions
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

   // ************************************************************
   // Control register
   // ************************************************************
   logic enable;
   logic en_fall;
   logic exit_req;
   logic rel_req;
   logic ctl_wr;

   assign ctl_wr = i_wr & (i_addr == OFS_CONTROL);
   assign exit_req = ctl_wr & i_wdata[BIT_COMM_EXIT];
   assign rel_req = ctl_wr & i_wdata[BIT_WAIT_REL];
   assign en_fall = enable & ctl_wr & ~i_wdata[BIT_ENABLE];

   // Only the enable bit is stored; exit and release act as pulses
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         enable <= 1'b0;
      end else if (ctl_wr) begin
         enable <= i_wdata[BIT_ENABLE];
      end
   end

   // ************************************************************
   // Byte position on the bus
   // ************************************************************
   logic [3:0] bit_cnt;
   logic addr_byte;
   logic first_clk;

   // First rising clock of a byte: after a start or after a ninth clock
   assign first_clk = scl_rise & ((bit_cnt == CNT_IDLE) |
                                  (bit_cnt == CNT_NINTH));

   // Counter restarts at each start so a repeated start is tracked
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         bit_cnt <= CNT_IDLE;
         addr_byte <= 1'b0;
      end else if (!enable || start_det || stop_det) begin
         bit_cnt <= CNT_IDLE;
         addr_byte <= start_det & enable;
      end else if (scl_rise) begin
         bit_cnt <= first_clk ? CNT_FIRST : bit_cnt + 4'h1;
         if (bit_cnt == CNT_NINTH) begin
            addr_byte <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Event flags
   // ************************************************************
   logic ack_seen_flag;
   logic start_seen_flag;
   logic stop_seen_flag;
   logic ack_set;

   assign ack_set = scl_rise & (bit_cnt == CNT_EIGHTH) & ~sda_s;

   // Acknowledge: data low on ninth rising clock
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_seen_flag <= 1'b0;
      end else if (!enable || en_fall || exit_req || stop_det) begin
         ack_seen_flag <= 1'b0;
      end else if (ack_set) begin
         ack_seen_flag <= 1'b1;
      end else if (first_clk) begin
         ack_seen_flag <= 1'b0;
      end
   end

   // Start: marks the address byte until the next byte begins
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         start_seen_flag <= 1'b0;
      end else if (!enable || en_fall) begin
         start_seen_flag <= 1'b0;
      end else if (start_det) begin
         start_seen_flag <= 1'b1;
      end else if (stop_det || exit_req ||
                   (first_clk && bit_cnt == CNT_NINTH)) begin
         start_seen_flag <= 1'b0;
      end
   end

   // Stop: survives exit requests, so software can see bus release
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         stop_seen_flag <= 1'b0;
      end else if (!enable || en_fall) begin
         stop_seen_flag <= 1'b0;
      end else if (stop_det) begin
         stop_seen_flag <= 1'b1;
      end else if (first_clk && addr_byte) begin
         stop_seen_flag <= 1'b0;
      end
   end

   // ************************************************************
   // Transmit state, wait and pin drive
   // ************************************************************
   logic wait_hold;

   // Clock held low after the ninth clock until software releases it
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         wait_hold <= 1'b0;
      end else if (!enable || exit_req || stop_det) begin
         wait_hold <= 1'b0;
      end else if (wait_hold && (rel_req || i_shift_write)) begin
         wait_hold <= 1'b0;
      end else if (scl_fall && bit_cnt == CNT_NINTH) begin
         wait_hold <= 1'b1;
      end
   end

   // Release by the control bit drops back to reception
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_transmit_state_flag <= 1'b0;
      end else if (!enable || exit_req || stop_det) begin
         o_transmit_state_flag <= 1'b0;
      end else if (i_tx_state_set) begin
         o_transmit_state_flag <= 1'b1;
      end else if (wait_hold && rel_req) begin
         o_transmit_state_flag <= 1'b0;
      end
   end

   // Open-drain: only ever pull low; enable low means driving
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_data_line_pin <= 1'b0;
         o_data_line_pin_oe_n <= 1'b1;
         o_clock_line_pin <= 1'b0;
         o_clock_line_pin_oe_n <= 1'b1;
      end else begin
         o_data_line_pin <= 1'b0;
         o_data_line_pin_oe_n <= ~(enable & o_transmit_state_flag &
                                   ~i_tx_bit);
         o_clock_line_pin <= 1'b0;
         o_clock_line_pin_oe_n <= ~wait_hold;
      end
   end

   // ************************************************************
   // Interrupt status and mask
   // ************************************************************
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] irq_evt;
   logic irq_st_wr;

   assign irq_evt = {ack_set & enable, start_det & enable,
                     stop_det & enable};
   assign irq_st_wr = i_wr & (i_addr == OFS_IRQ_STATUS);

   // Write one clears; a new event in the same cycle wins
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_status <= EVT_RESET;
      end else begin
         irq_status <= (irq_status & ~(irq_st_wr ? i_wdata[2:0] : 3'h0))
                       | irq_evt;
      end
   end

   // Mask bits enable the matching status bits
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_mask <= EVT_RESET;
      end else if (i_wr && i_addr == OFS_IRQ_MASK) begin
         irq_mask <= i_wdata[2:0];
      end
   end

   // Registered level output, one cycle behind the status
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status & irq_mask);
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   logic [DATA_W-1:0] next_rdata;

   // Writes to the status word are ignored entirely
   always_comb begin
      next_rdata = RDATA_RESET;
      case (i_addr)
         OFS_STATUS: begin
            next_rdata[BIT_TX_STATE] = o_transmit_state_flag;
            next_rdata[BIT_ACK] = ack_seen_flag;
            next_rdata[BIT_START] = start_seen_flag;
            next_rdata[BIT_STOP] = stop_seen_flag;
         end
         OFS_CONTROL: next_rdata[BIT_ENABLE] = enable;
         OFS_IRQ_STATUS: next_rdata[2:0] = irq_status;
         OFS_IRQ_MASK: next_rdata[2:0] = irq_mask;
         default: next_rdata = RDATA_RESET;
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= RDATA_RESET;
      end else begin
         o_rdata <= i_rd ? next_rdata : RDATA_RESET;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);

   sequence s_ninth_low;
      enable && !en_fall && !exit_req && ack_set;
   endsequence

   sequence s_release_tx;
      enable && wait_hold && o_transmit_state_flag && rel_req &&
      !exit_req && !stop_det && !i_tx_state_set;
   endsequence

   a_ack_set_ninth: assert property (s_ninth_low |=> ack_seen_flag)
      else $error("ack flag not set on ninth clock");
   a_ack_clear_first: assert property (
      first_clk && !ack_set |=> !ack_seen_flag)
      else $error("ack flag not cleared at first clock");
   a_start_set_cond: assert property (
      enable && !en_fall && start_det |=> start_seen_flag)
      else $error("start flag not set");
   a_start_clear_data: assert property (first_clk &&
      bit_cnt == CNT_NINTH && !start_det |=> !start_seen_flag)
      else $error("start flag not cleared after address");
   a_stop_set_cond: assert property (enable && !en_fall && stop_det
      |=> stop_seen_flag && !start_seen_flag && !ack_seen_flag)
      else $error("stop condition not flagged");
   a_stop_hold_flag: assert property (stop_seen_flag && enable &&
      !en_fall && !(first_clk && addr_byte) |=> stop_seen_flag)
      else $error("stop flag dropped early");
   a_exit_clear_flags: assert property (exit_req && !start_det
      |=> !ack_seen_flag && !start_seen_flag)
      else $error("exit did not clear flags");
   a_release_tx_float: assert property (s_release_tx
      |=> !o_transmit_state_flag && !wait_hold ##1
      o_data_line_pin_oe_n)
      else $error("wait release in transmit left data driven");
   a_status_write_none: assert property (i_wr && i_addr == OFS_STATUS &&
      enable && !ctl_wr && !scl_rise && !start_det && !stop_det
      |=> $stable({ack_seen_flag, start_seen_flag, stop_seen_flag}))
      else $error("status write changed event flags");
   a_disable_clear_all: assert property (en_fall
      |=> !ack_seen_flag && !start_seen_flag && !stop_seen_flag)
      else $error("disable did not clear flags");
endmodule : i2c_bus_event_status_flags

// *** verification/bus_peer.sv ***
// Far-side bus master model on open-drain clock and data lines
`timescale 1ns/1ps
module bus_peer (
   // Device pin drivers
   input wire logic i_clk_oe_n,
   input wire logic i_clk_pin,
   input wire logic i_dat_oe_n,
   input wire logic i_dat_pin,
   // Resolved line levels
   output logic o_clock_line,
   output logic o_data_line
);
   logic scl_rel = 1'b1;
   logic sda_rel = 1'b1;
   logic stuck = 1'b0;
   // Wired-and with pull-ups: a released line reads high
   assign o_clock_line = scl_rel & (i_clk_oe_n | i_clk_pin);
   assign o_data_line = sda_rel & (i_dat_oe_n | i_dat_pin);
   // Release clock; a device wait stretches it, bounded
   task automatic rise();
      int n;
      n = 0;
      scl_rel = 1'b1;
      while (!o_clock_line && n < 4000) begin
         #10;
         n++;
      end
      if (!o_clock_line) stuck = 1'b1;
      #200;
   endtask : rise
   // Data falls while clock is high
   task automatic start_cond();
      sda_rel = 1'b1;
      #100;
      rise();
      sda_rel = 1'b0;
      #200;
      scl_rel = 1'b0;
      #100;
   endtask : start_cond
   // Data rises while clock is high; clock then stands still
   task automatic stop_cond();
      sda_rel = 1'b0;
      #100;
      rise();
      sda_rel = 1'b1;
      #200;
   endtask : stop_cond
   // Eight data bits then ninth clock; data only moves with clock low
   task automatic send_byte(input logic [7:0] d, input logic ack_low);
      for (int i = 0; i < 9; i++) begin
         sda_rel = (i < 8) ? d[7-i] : !ack_low;
         #100;
         rise();
         scl_rel = 1'b0;
         #100;
      end
      sda_rel = 1'b1;
   endtask : send_byte
endmodule : bus_peer

// *** verification/i2c_bus_event_status_flags_bench.sv ***
// Self-checking bench for the bus event status flags
`timescale 1ns/1ps
module i2c_bus_event_status_flags_bench;
   import i2c_evt_pkg::*;
   logic i_clk_sys, i_rstn, i_wr, i_rd, i_tx_state_set, i_tx_bit;
   logic i_shift_write, scl, sda, clk_o, clk_oe_n, dat_o, dat_oe_n;
   logic tx_flag, irq;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, rdata;
   int err_count = 0;
   int checks = 0;
   // ************************************************************
   // Instances
   // ************************************************************
   i2c_bus_event_status_flags i_i2c_bus_event_status_flags (
      .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
      .i_tx_state_set(i_tx_state_set), .i_tx_bit(i_tx_bit),
      .i_shift_write(i_shift_write), .i_clock_line_pin(scl),
      .o_clock_line_pin(clk_o), .o_clock_line_pin_oe_n(clk_oe_n),
      .i_data_line_pin(sda), .o_data_line_pin(dat_o),
      .o_data_line_pin_oe_n(dat_oe_n), .o_transmit_state_flag(tx_flag),
      .o_irq(irq));
   bus_peer i_bus_peer (.i_clk_oe_n(clk_oe_n), .i_clk_pin(clk_o),
      .i_dat_oe_n(dat_oe_n), .i_dat_pin(dat_o), .o_clock_line(scl),
      .o_data_line(sda));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk
   task automatic pulse_tx(input logic b);
      @(posedge i_clk_sys);
      i_tx_state_set <= 1'b1;
      i_tx_bit <= b;
      @(posedge i_clk_sys);
      i_tx_state_set <= 1'b0;
      cyc(2);
   endtask : pulse_tx
   task automatic conclude();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs();
      rd_chk(OFS_STATUS, 8'h00);
      rd_chk(OFS_CONTROL, 8'h00);
      rd_chk(OFS_IRQ_MASK, 8'h00);
      rd_chk(4'hF, 8'h00);
      wr(OFS_CONTROL, 8'h80);
      wr(OFS_STATUS, 8'h0F);
      rd_chk(OFS_STATUS, 8'h00);
      rd_chk(OFS_CONTROL, 8'h80);
      wr(OFS_IRQ_MASK, 8'h07);
      $display("test regs done");
   endtask : t_regs
   task automatic t_flow();
      i_bus_peer.start_cond();
      cyc(6);
      rd_chk(OFS_STATUS, 8'h02);
      wr(OFS_STATUS, 8'h00);
      rd_chk(OFS_STATUS, 8'h02);
      chk_bit(irq, 1'b1);
      i_bus_peer.send_byte(8'hA4, 1'b1);
      cyc(6);
      rd_chk(OFS_STATUS, 8'h06);
      chk_bit(clk_oe_n, 1'b0);
      wr(OFS_CONTROL, 8'hA0);
      cyc(3);
      chk_bit(clk_oe_n, 1'b1);
      i_bus_peer.send_byte(8'h5A, 1'b0);
      cyc(6);
      rd_chk(OFS_STATUS, 8'h00);
      wr(OFS_CONTROL, 8'hA0);
      i_bus_peer.send_byte(8'h3C, 1'b1);
      wr(OFS_CONTROL, 8'hA0);
      i_bus_peer.stop_cond();
      cyc(6);
      rd_chk(OFS_STATUS, 8'h01);
      i_bus_peer.start_cond();
      cyc(6);
      rd_chk(OFS_STATUS, 8'h03);
      i_bus_peer.send_byte(8'hA4, 1'b1);
      cyc(6);
      rd_chk(OFS_STATUS, 8'h06);
      wr(OFS_CONTROL, 8'hC0);
      cyc(3);
      rd_chk(OFS_STATUS, 8'h00);
      chk_bit(clk_oe_n, 1'b1);
      i_bus_peer.stop_cond();
      i_bus_peer.start_cond();
      cyc(6);
      wr(OFS_CONTROL, 8'h00);
      cyc(3);
      rd_chk(OFS_STATUS, 8'h00);
      wr(OFS_CONTROL, 8'h80);
      i_bus_peer.stop_cond();
      $display("test flow done");
   endtask : t_flow
   task automatic t_irq();
      wr(OFS_IRQ_MASK, 8'h00);
      wr(OFS_IRQ_STATUS, 8'h07);
      cyc(3);
      chk_bit(irq, 1'b0);
      i_bus_peer.start_cond();
      cyc(6);
      rd_chk(OFS_IRQ_STATUS, 8'h02);
      chk_bit(irq, 1'b0);
      wr(OFS_IRQ_MASK, 8'h02);
      cyc(3);
      chk_bit(irq, 1'b1);
      wr(OFS_IRQ_STATUS, 8'h02);
      cyc(3);
      chk_bit(irq, 1'b0);
      rd_chk(OFS_IRQ_STATUS, 8'h00);
      $display("test irq done");
   endtask : t_irq
   // Sending a zero first, so the release visibly floats the data line
   task automatic t_tx();
      pulse_tx(1'b0);
      chk_bit(tx_flag, 1'b1);
      chk_bit(dat_oe_n, 1'b0);
      chk_bit(dat_o, 1'b0);
      i_bus_peer.send_byte(8'hA4, 1'b1);
      cyc(6);
      chk_bit(clk_oe_n, 1'b0);
      chk_bit(clk_o, 1'b0);
      wr(OFS_CONTROL, 8'hA0);
      cyc(4);
      chk_bit(tx_flag, 1'b0);
      chk_bit(dat_oe_n, 1'b1);
      chk_bit(clk_oe_n, 1'b1);
      pulse_tx(1'b1);
      i_bus_peer.send_byte(8'h81, 1'b1);
      cyc(6);
      @(posedge i_clk_sys);
      i_shift_write <= 1'b1;
      @(posedge i_clk_sys);
      i_shift_write <= 1'b0;
      cyc(3);
      chk_bit(clk_oe_n, 1'b1);
      chk_bit(tx_flag, 1'b1);
      i_bus_peer.stop_cond();
      chk_bit(i_bus_peer.stuck, 1'b0);
      $display("test tx done");
   endtask : t_tx
   // ************************************************************
   // Clock, reset, sequence and watchdog
   // ************************************************************
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // Main sequence; inputs valued at time zero
   initial begin
      i_rstn = 1'b0;
      {i_wr, i_rd, i_tx_state_set, i_tx_bit, i_shift_write} = 5'h02;
      i_addr = 4'h0;
      i_wdata = 8'h00;
      repeat (16) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      t_regs();
      t_flow();
      t_irq();
      t_tx();
      conclude();
   end
   // Cuts a hang short
   initial begin
      #2000000;
      err_count++;
      conclude();
   end
endmodule : i2c_bus_event_status_flags_bench
